// ==== src/pwe_regs.svh ====
`ifndef PWE_REGS_SVH
`define PWE_REGS_SVH

// register byte offsets
`define PWE_OFF_TARGET 12'h310
`define PWE_OFF_COMMAND 12'h314
`define PWE_OFF_QUEUE 12'h318

// target register fields
`define PWE_COUNT_MSB 31
`define PWE_COUNT_LSB 16
`define PWE_ADDR_MSB 15
`define PWE_ADDR_LSB 0

// command register fields
`define PWE_BIT_IN_PROGRESS 31
`define PWE_BIT_CANCEL 30
`define PWE_FREE_CNT_MSB 12
`define PWE_FREE_CNT_LSB 8
`define PWE_BIT_FREE_FLAG 0

// reset values
`define PWE_RST_COUNT 16'h0000
`define PWE_RST_ADDR 16'h0000
`define PWE_RST_FREE_CNT 5'h10
`define PWE_RST_FREE_FLAG 1'h1

// queue geometry
`define PWE_QUEUE_DEPTH 16
`define PWE_QUEUE_WIDTH 32

`endif

// ==== src/pwe_pkg.sv ====
package pwe_pkg;

  // engine states
  typedef enum logic [0:0] {
    PWE_IDLE = 1'b0,
    PWE_RUN = 1'b1
  } pwe_state_t;

endpackage

// ==== src/pwe_fifo.sv ====
`timescale 1ns/100ps
// dword queue between host writes and the memory engine
module pwe_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // flush
  input wire logic i_flush,
  // fill side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // drain side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data,
  // free slots
  output logic [CW-1:0] o_free_count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FREE_ALL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] free;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_free;
  logic push;
  logic pop;

  assign o_wr_ready = (free != {CW{1'b0}});
  assign o_rd_valid = (free != FREE_ALL);
  assign o_rd_data = mem[rd_ptr];
  assign o_free_count = free;
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_free = free;
    if (i_flush) begin
      next_wr_ptr = {PW{1'b0}};
      next_rd_ptr = {PW{1'b0}};
      next_free = FREE_ALL;
    end else begin
      if (push) begin
        next_wr_ptr = (wr_ptr == PTR_LAST) ? {PW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = (rd_ptr == PTR_LAST) ? {PW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        next_free = free - 1'b1;
      end else if (pop && !push) begin
        next_free = free + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      free <= FREE_ALL;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      free <= next_free;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push && !i_flush) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

endmodule

// ==== src/pwe_engine.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "pwe_regs.svh"
// Operation
// RULE1: writing one to in-progress starts transfer at target address for byte count
// RULE2: in-progress reads one during transfer, clears itself when all bytes written
// RULE3: writing zero to in-progress or cancel changes nothing
// RULE4: writing one to cancel ends any transfer; cancel clears itself
// RULE5: cancel clears in-progress, empties queue, restores free count and flag
// RULE6: byte count in upper half, resets zero, counts down per written byte
// RULE7: target address in lower half, resets zero, advances per written byte
// RULE8: host changes count and address only while in-progress reads zero
// RULE9: host keeps every transfer byte inside process memory range
// RULE10: free count drops when host writes a whole dword into queue
// RULE11: free count rises when engine drains data to process memory
// RULE12: free count tells safe dword writes, resets to sixteen
// RULE13: free flag reads one while queue accepts data, resets to one
// RULE14: engine stalls while queue empty, finishes when byte count reaches zero
module pwe_engine #(
  parameter int DEPTH = `PWE_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register port
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // process memory write port
  output logic o_mem_wr,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_data
);

  // state
  pwe_pkg::pwe_state_t state;
  pwe_pkg::pwe_state_t next_state;
  logic [15:0] byte_count;
  logic [15:0] next_byte_count;
  logic [15:0] target_addr;
  logic [15:0] next_target_addr;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic cancel_flag;
  logic next_cancel_flag;
  logic mem_wr;
  logic next_mem_wr;
  logic [15:0] mem_addr;
  logic [15:0] next_mem_addr;
  logic [7:0] mem_data;
  logic [7:0] next_mem_data;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // decode
  logic wr_target;
  logic wr_cmd;
  logic wr_queue;
  logic start;
  logic cancel;
  logic busy;
  logic can_send;
  logic last_of_word;

  // queue
  logic q_ready;
  logic q_valid;
  logic q_pop;
  logic [31:0] q_data;
  logic [4:0] free_cnt;
  logic free_flag;

  assign wr_target = i_reg_wr && (i_reg_addr == `PWE_OFF_TARGET);
  assign wr_cmd = i_reg_wr && (i_reg_addr == `PWE_OFF_COMMAND);
  assign wr_queue = i_reg_wr && (i_reg_addr == `PWE_OFF_QUEUE);
  assign start = wr_cmd && i_reg_wdata[`PWE_BIT_IN_PROGRESS]; // [RULE3]
  assign cancel = wr_cmd && i_reg_wdata[`PWE_BIT_CANCEL]; // [RULE3]
  assign busy = (state == pwe_pkg::PWE_RUN);
  // stall on an empty queue [RULE14]
  assign can_send = busy && (byte_count != 16'h0000) && q_valid && !cancel;
  assign last_of_word = (byte_idx == 2'h3) || (byte_count == 16'h0001);
  assign q_pop = can_send && last_of_word; // [RULE11]
  assign free_flag = (free_cnt != 5'h00); // [RULE13]

  pwe_fifo #(
    .WIDTH(`PWE_QUEUE_WIDTH),
    .DEPTH(DEPTH),
    .CW(5)
  ) u_queue (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_flush(cancel), // [RULE5]
    .i_wr_valid(wr_queue), // [RULE10]
    .o_wr_ready(q_ready),
    .i_wr_data(i_reg_wdata),
    .o_rd_valid(q_valid),
    .i_rd_ready(q_pop),
    .o_rd_data(q_data),
    .o_free_count(free_cnt) // [RULE12]
  );

  // engine next state
  always_comb begin
    next_state = state;
    next_byte_count = byte_count;
    next_target_addr = target_addr;
    next_byte_idx = byte_idx;
    next_cancel_flag = cancel; // [RULE4]
    next_mem_wr = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_data = mem_data;
    case (state)
      pwe_pkg::PWE_IDLE: begin
        if (wr_target) begin
          next_byte_count = i_reg_wdata[`PWE_COUNT_MSB:`PWE_COUNT_LSB]; // [RULE8]
          next_target_addr = i_reg_wdata[`PWE_ADDR_MSB:`PWE_ADDR_LSB]; // [RULE8]
        end
        if (start && !cancel) begin
          next_state = pwe_pkg::PWE_RUN; // [RULE1]
          next_byte_idx = 2'h0;
        end
      end
      pwe_pkg::PWE_RUN: begin
        if (cancel) begin
          next_state = pwe_pkg::PWE_IDLE; // [RULE4] [RULE5]
          next_byte_idx = 2'h0;
        end else if (byte_count == 16'h0000) begin
          next_state = pwe_pkg::PWE_IDLE; // [RULE14]
        end else if (can_send) begin
          next_mem_wr = 1'b1;
          next_mem_addr = target_addr; // [RULE1]
          next_mem_data = q_data[{byte_idx, 3'b000} +: 8];
          next_byte_count = byte_count - 16'h0001; // [RULE6]
          next_target_addr = target_addr + 16'h0001; // [RULE7]
          next_byte_idx = last_of_word ? 2'h0 : byte_idx + 2'h1;
          if (byte_count == 16'h0001) begin
            next_state = pwe_pkg::PWE_IDLE; // [RULE2]
          end
        end
      end
      default: begin
        next_state = pwe_pkg::PWE_IDLE;
      end
    endcase
  end

  // read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `PWE_OFF_TARGET: begin
          next_rdata = {byte_count, target_addr};
        end
        `PWE_OFF_COMMAND: begin
          next_rdata[`PWE_BIT_IN_PROGRESS] = busy; // [RULE2]
          next_rdata[`PWE_BIT_CANCEL] = cancel_flag;
          next_rdata[`PWE_FREE_CNT_MSB:`PWE_FREE_CNT_LSB] = free_cnt; // [RULE12]
          next_rdata[`PWE_BIT_FREE_FLAG] = free_flag; // [RULE13]
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= pwe_pkg::PWE_IDLE;
      byte_count <= `PWE_RST_COUNT;
      target_addr <= `PWE_RST_ADDR;
      byte_idx <= 2'h0;
      cancel_flag <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_data <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      byte_count <= next_byte_count;
      target_addr <= next_target_addr;
      byte_idx <= next_byte_idx;
      cancel_flag <= next_cancel_flag;
      mem_wr <= next_mem_wr;
      mem_addr <= next_mem_addr;
      mem_data <= next_mem_data;
      rdata <= next_rdata;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_mem_wr = mem_wr;
  assign o_mem_addr = mem_addr;
  assign o_mem_data = mem_data;

  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  AST_START_RUNS: assert property ( // [RULE1]
    (start && !cancel && !busy) |=> busy ##1 (o_mem_wr || !q_valid || byte_count == 16'h0000)
  ) else $error("start did not begin a transfer");

  AST_DONE_CLEARS: assert property ( // [RULE2]
    (busy && can_send && byte_count == 16'h0001) |=> !busy && o_mem_wr
  ) else $error("in-progress not cleared after last byte");

  AST_ZERO_NO_EFFECT: assert property ( // [RULE3]
    (wr_cmd && i_reg_wdata[31:30] == 2'b00) |=> (busy == $past(busy))
  ) else $error("zero write changed engine state");

  AST_CANCEL_STOPS: assert property ( // [RULE4]
    cancel |=> !busy && cancel_flag ##1 (!cancel_flag || $past(cancel))
  ) else $error("cancel did not stop or self clear");

  AST_CANCEL_RESETS: assert property ( // [RULE5]
    cancel |=> free_cnt == `PWE_RST_FREE_CNT && free_flag && !q_valid
  ) else $error("cancel did not reset queue status");

  AST_COUNT_DOWN: assert property ( // [RULE6]
    can_send |=> byte_count == $past(byte_count) - 16'h0001
  ) else $error("byte count did not decrement");

  AST_ADDR_UP: assert property ( // [RULE7]
    can_send |=> target_addr == $past(target_addr) + 16'h0001 && o_mem_addr == $past(target_addr)
  ) else $error("target address did not advance");

  AST_FREE_DEC: assert property ( // [RULE10]
    (wr_queue && q_ready && !q_pop && !cancel) |=> free_cnt == $past(free_cnt) - 5'h01
  ) else $error("free count did not drop on push");

  AST_FREE_INC: assert property ( // [RULE11]
    (q_pop && !wr_queue) |=> free_cnt == $past(free_cnt) + 5'h01
  ) else $error("free count did not rise on drain");

  AST_FREE_BOUND: assert property ( // [RULE12]
    free_cnt <= `PWE_RST_FREE_CNT
  ) else $error("free count above queue depth");

  AST_FULL_HOLDS: assert property ( // [RULE13]
    (!free_flag && !q_pop && !cancel) |=> !free_flag
  ) else $error("full queue accepted data");

  AST_STALL_EMPTY: assert property ( // [RULE14]
    (busy && !q_valid) |=> !o_mem_wr
  ) else $error("memory written from empty queue");

endmodule

// ==== verif/pwe_mem_model.sv ====
`timescale 1ns/100ps
// process memory beside the engine: records every byte write, never stalls
module pwe_mem_model (
  // clock
  input wire logic i_clk_sys,
  // byte write port from the engine
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_data
);
  logic [7:0] bytes [0:65535];
  int n_wr = 0;
  always @(posedge i_clk_sys) begin
    if (i_mem_wr === 1'b1) begin
      bytes[i_mem_addr] <= i_mem_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`include "pwe_regs.svh"
module tb;
  logic i_clk_sys;
  logic i_rst_n;
  logic [11:0] i_reg_addr;
  logic [31:0] i_reg_wdata;
  logic i_reg_wr;
  logic i_reg_rd;
  logic [31:0] o_reg_rdata;
  logic o_mem_wr;
  logic [15:0] o_mem_addr;
  logic [7:0] o_mem_data;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int base;
  localparam logic [11:0] CMD = `PWE_OFF_COMMAND;
  localparam logic [11:0] TGT = `PWE_OFF_TARGET;
  localparam logic [11:0] QUE = `PWE_OFF_QUEUE;

  pwe_engine dut (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr),
    .o_mem_data(o_mem_data)
  );

  pwe_mem_model mem_i (
    .i_clk_sys(i_clk_sys),
    .i_mem_wr(o_mem_wr),
    .i_mem_addr(o_mem_addr),
    .i_mem_data(o_mem_data)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata & m, e);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b1;
      i_reg_addr <= CMD;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1;
      if (o_reg_rdata[31] === 1'b0) break;
    end
    if (i == 100) begin
      err_count++;
      $display("[FAIL] %0t engine stays busy", $time);
    end
  endtask

  // bytes land low byte first at ascending addresses
  task automatic chk_bytes(input logic [15:0] a, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      chk8(mem_i.bytes[a + 16'(i)], v[8*i +: 8]);
    end
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_reg_addr = 12'h000;
    i_reg_wdata = 32'h0000_0000;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_1001);
    rdc(TGT, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(12'h31C, 32'hFFFF_FFFF, 32'h0000_0000);
    // prefill two dwords, then run six bytes
    wr(QUE, 32'h4433_2211);
    wr(QUE, 32'h8877_6655);
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_0E01);
    wr(TGT, 32'h0006_1000);
    wr(CMD, 32'h0000_0000);
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_0E01);
    chk(32'(mem_i.n_wr), 32'h0000_0000);
    wr(CMD, 32'h8000_0000);
    rdc(CMD, 32'h8000_0000, 32'h8000_0000);
    wait_idle();
    chk_bytes(16'h1000, 32'h4433_2211, 4);
    chk_bytes(16'h1004, 32'h8877_6655, 2);
    chk(32'(mem_i.n_wr), 32'h0000_0006);
    rdc(TGT, 32'hFFFF_FFFF, 32'h0000_1006);
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_1001);
    // start on an empty queue stalls until data arrive
    base = mem_i.n_wr;
    wr(TGT, 32'h0004_1100);
    wr(CMD, 32'h8000_0000);
    repeat (10) @(posedge i_clk_sys);
    chk(32'(mem_i.n_wr - base), 32'h0000_0000);
    wr(CMD, 32'h0000_0000);
    rdc(CMD, 32'h8000_0000, 32'h8000_0000);
    wr(QUE, 32'hDDCC_BBAA);
    wait_idle();
    chk_bytes(16'h1100, 32'hDDCC_BBAA, 4);
    rdc(TGT, 32'hFFFF_FFFF, 32'h0000_1104);
    // cancel in mid-transfer
    wr(TGT, 32'h0008_1200);
    wr(CMD, 32'h8000_0000);
    wr(QUE, 32'h0403_0201);
    repeat (8) @(posedge i_clk_sys);
    wr(CMD, 32'h4000_0000);
    rdc(CMD, 32'hBFFF_FFFF, 32'h0000_1001);
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_1001);
    chk(32'(mem_i.n_wr - base), 32'h0000_0008);
    chk_bytes(16'h1200, 32'h0403_0201, 4);
    // fill the queue until it refuses, then cancel flushes it
    for (int i = 0; i < 16; i++) begin
      wr(QUE, 32'(i));
    end
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(QUE, 32'h0000_1234);
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(CMD, 32'h4000_0000);
    rdc(CMD, 32'hFFFF_FFFF, 32'h0000_1001);
    wr(TGT, 32'h0004_1300);
    wr(CMD, 32'h8000_0000);
    repeat (10) @(posedge i_clk_sys);
    chk(32'(mem_i.n_wr - base), 32'h0000_0008);
    wr(CMD, 32'h4000_0000);
    // zero count finishes at once
    wr(TGT, 32'h0000_1400);
    wr(CMD, 32'h8000_0000);
    wait_idle();
    chk(32'(mem_i.n_wr - base), 32'h0000_0008);
    close_out();
  end
endmodule
